// ---- rtl/svm_monitor.sv ----
// The plain strobed port and the register addresses were chosen for this implementation.
module svm_monitor
	import svm_pkg::*;
(
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	input  wire logic [svm_pkg::ADDR_W-1:0] bus_addr,
	input  wire logic [svm_pkg::DATA_W-1:0] bus_wdata,
	input  wire logic                      bus_wr,
	input  wire logic                      bus_rd,
	output logic      [svm_pkg::DATA_W-1:0] bus_rdata,
	input  wire svm_pkg::svm_cmp_t         cmp_async,
	input  wire logic                      wait_mode,
	input  wire logic                      stop_mode,
	output logic                           monitor_powered,
	output logic                           trip_level_select,
	output logic                           reset_request,
	output logic                           undervoltage_flag
);
	import svm_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	svm_cmp_t              sync_stage1;
	svm_cmp_t              sync_stage2;
	svm_option_t           option;
	svm_option_t           next_option;
	logic                  options_locked;
	logic                  next_options_locked;
	logic                  flag;
	logic                  next_flag;
	svm_state_t            state;
	svm_state_t            next_state;
	logic                  level_raise;
	logic                  next_level_raise;
	logic [1:0]            raise_pipe;
	logic [1:0]            next_raise_pipe;
	logic [DATA_W-1:0]     rdata;
	logic [DATA_W-1:0]     next_rdata;
	logic                  monitor_active;
	logic                  reset_armed;
	logic                  cmp_below;
	logic                  cmp_above;
	logic                  opt_write;
	logic                  stat_read;
	logic                  opt_read;
	logic [DATA_W-1:0]     opt_word;
	logic [DATA_W-1:0]     stat_word;

	// ****************************************
	// Comparator synchroniser
	// ****************************************
	// two flop sync
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync_stage1 <= '0;
			sync_stage2 <= '0;
		end else begin
			sync_stage1 <= cmp_async;
			sync_stage2 <= sync_stage1;
		end
	end

	assign cmp_below = sync_stage2.below_falling;
	assign cmp_above = sync_stage2.above_rising;

	// ****************************************
	// Activity decode
	// ****************************************
	// power disable gates
	always_comb begin
		monitor_active = 1'b0;
		if (!option.monitor_power_disable) begin
			if (stop_mode) begin
				monitor_active = option.monitor_in_stop_enable;
			end else begin
				monitor_active = 1'b1;
			end
		end
	end

	assign reset_armed = monitor_active && !option.monitor_reset_disable;

	// ****************************************
	// Register port decode
	// ****************************************
	assign opt_write = bus_wr && (bus_addr == OFS_OPTION_CONFIG_WORD);
	assign opt_read  = bus_rd && (bus_addr == OFS_OPTION_CONFIG_WORD);
	assign stat_read = bus_rd && (bus_addr == OFS_SUPPLY_MONITOR_STATUS);

	// ****************************************
	// Option word
	// ****************************************
	always_comb begin
		next_option         = option;
		next_options_locked = options_locked;
		next_level_raise    = 1'b0;
		if (opt_write) begin
			next_option.monitor_reset_disable = bus_wdata[POS_MONITOR_RESET_DISABLE];
			next_option.trip_level_select     = bus_wdata[POS_TRIP_LEVEL_SELECT];
			next_level_raise = (option.trip_level_select == TRIP_RESET_LEVEL)
				&& (bus_wdata[POS_TRIP_LEVEL_SELECT] == TRIP_WARNING_LEVEL);
			if (!options_locked) begin
				next_option.monitor_power_disable =
					bus_wdata[POS_MONITOR_POWER_DISABLE];
				next_option.monitor_in_stop_enable =
					bus_wdata[POS_MONITOR_IN_STOP_ENABLE];
				next_options_locked = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			option.monitor_reset_disable  <= RST_MONITOR_RESET_DISABLE;
			option.trip_level_select      <= RST_TRIP_LEVEL_SELECT;
			option.monitor_power_disable  <= RST_MONITOR_POWER_DISABLE;
			option.monitor_in_stop_enable <= RST_MONITOR_IN_STOP_ENABLE;
			options_locked                <= 1'b0;
			level_raise                   <= 1'b0;
			raise_pipe                    <= 2'h0;
		end else begin
			option         <= next_option;
			options_locked <= next_options_locked;
			level_raise    <= next_level_raise;
			raise_pipe     <= next_raise_pipe;
		end
	end

	// Raise waits for new level through synchroniser
	assign next_raise_pipe = {raise_pipe[0], level_raise};

	// ****************************************
	// Undervoltage flag
	// ****************************************
	// hysteretic follow
	always_comb begin
		next_flag = flag;
		if (monitor_active) begin
			if (cmp_below) begin
				next_flag = 1'b1;
			end else if (cmp_above) begin
				next_flag = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			flag <= RST_UNDERVOLTAGE_FLAG;
		end else begin
			flag <= next_flag;
		end
	end

	// ****************************************
	// Reset request sequencer
	// ****************************************
	always_comb begin
		next_state = state;
		case (state)
			SVM_RUN: begin
				if (reset_armed && cmp_below) begin
					next_state = SVM_HOLD;
				end else if (reset_armed && raise_pipe[1] && !cmp_above) begin
					next_state = SVM_HOLD;
				end
			end
			SVM_HOLD: begin
				if (cmp_above) begin
					next_state = SVM_RUN;
				end
			end
			default: begin
				next_state = SVM_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= SVM_RUN;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	always_comb begin
		opt_word = '0;
		opt_word[POS_MONITOR_RESET_DISABLE]  = option.monitor_reset_disable;
		opt_word[POS_TRIP_LEVEL_SELECT]      = option.trip_level_select;
		opt_word[POS_MONITOR_POWER_DISABLE]  = option.monitor_power_disable;
		opt_word[POS_MONITOR_IN_STOP_ENABLE] = option.monitor_in_stop_enable;
	end

	always_comb begin
		stat_word = '0;
		stat_word[POS_UNDERVOLTAGE_FLAG] = flag;
		stat_word[POS_MONITOR_ACTIVE]    = monitor_active;
		stat_word[POS_RESET_REQUEST]     = (state == SVM_HOLD);
		stat_word[POS_OPTIONS_LOCKED]    = options_locked;
	end

	always_comb begin
		next_rdata = '0;
		if (stat_read) begin
			next_rdata = stat_word;
		end else if (opt_read) begin
			next_rdata = opt_word;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else begin
			rdata <= next_rdata;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// no interrupt output
	assign bus_rdata         = rdata;
	assign undervoltage_flag = flag;
	assign reset_request     = (state == SVM_HOLD);
	assign trip_level_select = option.trip_level_select;
	assign monitor_powered   = monitor_active;

endmodule : svm_monitor

// ---- rtl/svm_pkg.sv ----
package svm_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	localparam logic [ADDR_W-1:0] OFS_OPTION_CONFIG_WORD   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SUPPLY_MONITOR_STATUS = 8'h04;

	// ****************************************
	// Option word field positions
	// ****************************************
	localparam int POS_MONITOR_RESET_DISABLE  = 0;
	localparam int POS_TRIP_LEVEL_SELECT      = 1;
	localparam int POS_MONITOR_POWER_DISABLE  = 2;
	localparam int POS_MONITOR_IN_STOP_ENABLE = 3;

	// ****************************************
	// Status word field positions
	// ****************************************
	localparam int POS_UNDERVOLTAGE_FLAG = 0;
	localparam int POS_MONITOR_ACTIVE    = 1;
	localparam int POS_RESET_REQUEST     = 2;
	localparam int POS_OPTIONS_LOCKED    = 3;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic RST_MONITOR_RESET_DISABLE  = 1'b0;
	localparam logic RST_TRIP_LEVEL_SELECT      = 1'b0;
	localparam logic RST_MONITOR_POWER_DISABLE  = 1'b0;
	localparam logic RST_MONITOR_IN_STOP_ENABLE = 1'b0;
	localparam logic RST_UNDERVOLTAGE_FLAG      = 1'b0;

	// Trip level encodings
	localparam logic TRIP_RESET_LEVEL   = 1'b0;
	localparam logic TRIP_WARNING_LEVEL = 1'b1;

	// Synchroniser depth
	localparam int SYNC_STAGES = 2;

	typedef struct packed {
		logic monitor_in_stop_enable;
		logic monitor_power_disable;
		logic trip_level_select;
		logic monitor_reset_disable;
	} svm_option_t;

	typedef struct packed {
		logic below_falling;
		logic above_rising;
	} svm_cmp_t;

	typedef enum logic [0:0] {
		SVM_RUN  = 1'b0,
		SVM_HOLD = 1'b1
	} svm_state_t;

endpackage : svm_pkg

// ---- sim/supply_undervoltage_monitor_test.sv ----
module supply_undervoltage_monitor_test
	import svm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] OPT = OFS_OPTION_CONFIG_WORD;
	localparam logic [7:0] STS = OFS_SUPPLY_MONITOR_STATUS;
	logic              ref_clk = 1'h0, rst = 1'h1, bus_wr = 1'h0, bus_rd = 1'h0;
	logic              wait_mode = 1'h0, stop_mode = 1'h0, rd_seen = 1'h0;
	logic [ADDR_W-1:0] bus_addr = 8'h00;
	logic [DATA_W-1:0] bus_wdata = 8'h00, bus_rdata;
	logic [15:0]       supply_mv = 16'h0BB8;
	svm_cmp_t          cmp_async;
	logic              monitor_powered, trip_level_select, reset_request, undervoltage_flag;
	logic [7:0]        exp_q[$];
	int                num_errors = 0, check_count = 0, cycles = 0;

	svm_monitor DUT (.ref_clk, .rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
		.cmp_async, .wait_mode, .stop_mode, .monitor_powered, .trip_level_select,
		.reset_request, .undervoltage_flag);
	svm_supply_model SUPPLY (.supply_mv, .trip_level_select, .cmp_async);

	initial forever #10 ref_clk = ~ref_clk;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic final_report;
		if (num_errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'h1;
		@(posedge ref_clk);
		bus_wr <= 1'h0;
		@(posedge ref_clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus_addr <= a;
		bus_rd <= 1'h1;
		@(posedge ref_clk);
		bus_rd <= 1'h0;
		@(posedge ref_clk);
	endtask : rd

	// Move supply, let synchroniser settle, read status
	task automatic probe(input logic [15:0] mv, input logic [7:0] e);
		supply_mv <= mv;
		repeat (4) @(posedge ref_clk);
		rd(STS, e);
	endtask : probe

	task automatic do_rst;
		rst <= 1'h1;
		@(posedge ref_clk);
		rst <= 1'h0;
	endtask : do_rst

	// Read-data watcher and run limit
	always @(posedge ref_clk) begin
		if (rd_seen) begin
			chk(bus_rdata, exp_q.pop_front());
		end
		rd_seen <= bus_rd;
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			num_errors++;
			final_report;
		end
	end

	initial begin
		void'($urandom(32'h3B32));
		repeat (12) @(posedge ref_clk);
		rst <= 1'h0;
		rd(OPT, 8'h00);
		rd(STS, 8'h02);
		rd(8'h08, 8'h00);
		wr(OPT, {4'($urandom), 4'h1});
		rd(OPT, 8'h01);
		probe(16'h07D0 + 16'($urandom & 32'hFF), 8'h0B);
		probe(16'h092E, 8'h0B);
		probe(16'h0BB8, 8'h0A);
		wr(OPT, 8'h03);
		probe(16'h09C4, 8'h0B);
		wr(OPT, 8'h00);
		probe(16'h09C4, 8'h0A);
		probe(16'h08E8, 8'h0F);
		probe(16'h092E, 8'h0F);
		probe(16'h0A5A, 8'h0A);
		wr(OPT, 8'h02);
		probe(16'h0A5A, 8'h0E);
		wait_mode <= 1'h1;
		probe(16'h0BB8, 8'h0A);
		probe(16'h09C4, 8'h0F);
		wait_mode <= 1'h0;
		probe(16'h0BB8, 8'h0A);
		stop_mode <= 1'h1;
		probe(16'h09C4, 8'h08);
		stop_mode <= 1'h0;
		probe(16'h09C4, 8'h0F);
		do_rst;
		rd(STS, 8'h02);
		wr(OPT, 8'h05);
		probe(16'h07D0, 8'h08);
		wr(OPT, 8'h00);
		rd(OPT, 8'h04);
		do_rst;
		wr(OPT, 8'h09);
		stop_mode <= 1'h1;
		probe(16'h07D0, 8'h0B);
		final_report;
	end
endmodule : supply_undervoltage_monitor_test

// ---- sim/svm_monitor_chk_sva.sv ----
module svm_monitor_chk
	import svm_pkg::*;
(
	input wire logic                        ref_clk,
	input wire logic                        rst,
	input wire logic [svm_pkg::ADDR_W-1:0]  bus_addr,
	input wire logic [svm_pkg::DATA_W-1:0]  bus_wdata,
	input wire logic                        bus_wr,
	input wire logic                        bus_rd,
	input wire logic [svm_pkg::DATA_W-1:0]  bus_rdata,
	input wire svm_pkg::svm_cmp_t           cmp_async,
	input wire logic                        monitor_powered,
	input wire logic                        trip_level_select,
	input wire logic                        reset_request,
	input wire logic                        undervoltage_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// ********
	// Flag, request and trip select timing
	// ********
	flag_set_a: assert property (
		(cmp_async.below_falling && monitor_powered)[*3] |=> undervoltage_flag)
		else $error("flag not set");
	flag_clr_a: assert property (
		(cmp_async.above_rising && !cmp_async.below_falling && monitor_powered)[*3]
		|=> !undervoltage_flag) else $error("flag not cleared");
	flag_hold_a: assert property (!monitor_powered |=> $stable(undervoltage_flag))
		else $error("flag moved while off");
	req_rise_a: assert property ($rose(reset_request) |->
		$past(cmp_async.below_falling, 3) ||
		($past(trip_level_select, 3) && !$past(trip_level_select, 4)))
		else $error("request without cause");
	req_fall_a: assert property ($fell(reset_request) |-> $past(cmp_async.above_rising, 3))
		else $error("request dropped early");
	req_hold_a: assert property ((reset_request && !cmp_async.above_rising)[*3]
		|=> reset_request) else $error("request not held");
	rd_flag_a: assert property ($past(bus_rd) &&
		$past(bus_addr) == OFS_SUPPLY_MONITOR_STATUS
		|-> bus_rdata[POS_UNDERVOLTAGE_FLAG] == $past(undervoltage_flag))
		else $error("status flag wrong");
	trip_wr_a: assert property ($past(bus_wr) &&
		$past(bus_addr) == OFS_OPTION_CONFIG_WORD
		|-> trip_level_select == $past(bus_wdata[POS_TRIP_LEVEL_SELECT]))
		else $error("trip select not written");
	cover property ($rose(reset_request));
	cover property ($fell(undervoltage_flag));
	cover property ($rose(trip_level_select));
endmodule : svm_monitor_chk

bind svm_monitor svm_monitor_chk u_chk (.ref_clk, .rst, .bus_addr, .bus_wdata, .bus_wr,
	.bus_rd, .bus_rdata, .cmp_async, .monitor_powered, .trip_level_select,
	.reset_request, .undervoltage_flag);

// ---- sim/svm_supply_model.sv ----
module svm_supply_model
	import svm_pkg::*;
#(
	parameter logic [15:0] WARN_FALL  = 16'h0A28,
	parameter logic [15:0] WARN_RISE  = 16'h0A8C,
	parameter logic [15:0] RESET_FALL = 16'h08FC,
	parameter logic [15:0] RESET_RISE = 16'h0960
)
(
	input  wire logic [15:0]  supply_mv,
	input  wire logic         trip_level_select,
	output svm_pkg::svm_cmp_t cmp_async
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// Comparator with hysteresis
	// ********
	// level pick, band
	always_comb begin
		if (trip_level_select == TRIP_WARNING_LEVEL) begin
			cmp_async.below_falling = supply_mv < WARN_FALL;
			cmp_async.above_rising  = supply_mv > WARN_RISE;
		end else begin
			cmp_async.below_falling = supply_mv < RESET_FALL;
			cmp_async.above_rising  = supply_mv > RESET_RISE;
		end
	end
endmodule : svm_supply_model
